/* hw/ccs_charge_cycle_sequencer.sv */
// charge cycle sequencer: state flow, timers, status pin, apb registers
//
// Function
// (RQ1) stay shut down while below lockout
// (RQ2) leave shutdown only with 150 mV margin
// (RQ3) margin loss forces shutdown from anywhere
// (RQ4) overvoltage forces shutdown, hysteresis releases
// (RQ5) operate only between both lockout thresholds
// (RQ6) power-down within 50 mV forces shutdown
// (RQ7) start needs power-down clear and enable
// (RQ8) high impedance program pin holds standby
// (RQ9) start charge below recharge threshold
// (RQ10) above regulation plus hysteresis suspends charge
// (RQ11) low battery precondition at ten percent
// (RQ12) above precondition threshold go fast charge
// (RQ13) precondition option fixed by build parameter
// (RQ14) precondition timeout faults and holds fault
// (RQ15) battery removal leaves fault into standby
// (RQ16) full current until regulation voltage reached
// (RQ17) safety timer cleared on fast entry
// (RQ18) status pin open drain, sink or float
// (RQ19) status sinks while charging, flashes on fault
// (RQ20) safety timeout in fast charge faults
// (RQ21) two-flop flag sync, prescaled timers
`timescale 1ns/1ps
module ccs_charge_cycle_sequencer #(
  parameter logic [31:0] TICK_CYCLES = 32'(ccs_pkg::TICK_CYC),
  parameter logic [31:0] PRE_TIMEOUT = 32'(ccs_pkg::PRE_TICKS),
  parameter logic [31:0] SAFE_TIMEOUT = 32'(ccs_pkg::SAFE_TICKS),
  parameter logic [31:0] FLASH_TICKS = 32'(ccs_pkg::FLASH_HALF),
  parameter bit PRECOND_EN = 1'b1,
  parameter bit PRE_TIMER_EN = 1'b1,
  parameter bit SAFE_TIMER_EN = 1'b1,
  parameter bit AUTO_RECHARGE = 1'b1,
  parameter bit FLASH_TYPE = 1'b0
) (
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  input wire logic UNDERVOLTAGE_LOCKOUT_OK_I,
  input wire logic VDD_MARGIN_OK_I,
  input wire logic POWER_DOWN_OK_I,
  input wire logic INPUT_OVERVOLTAGE_GUARD_I,
  input wire logic CHARGE_ENABLE_HIGH_I,
  input wire logic CURRENT_SET_ENABLE_PIN_HIZ_I,
  input wire logic BAT_BELOW_RECHARGE_THRESHOLD_I,
  input wire logic BAT_ABOVE_REGULATION_HYS_I,
  input wire logic BAT_BELOW_PRECOND_I,
  input wire logic BAT_AT_REGULATION_VOLTAGE_I,
  input wire logic TERM_CURRENT_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ccs_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic STAT_O,
  output logic STAT_OE_N_O,
  output logic CHG_ON_O,
  output logic CHG_LOW_CURRENT_O
);
  import ccs_pkg::*;

  // registered image and its next value
  ccs_reg_s cur;
  ccs_reg_s next_cur;
  // raw comparator flags gathered
  logic [NFLAG-1:0] raw;
  // synchronised flags, read from second stage only
  logic s_undervoltage_lockout;
  logic s_margin;
  logic s_pd;
  logic s_ovp;
  logic s_en;
  logic s_hiz;
  logic s_rechg;
  logic s_ovchg;
  logic s_pre;
  logic s_reg;
  logic s_term;
  // derived qualifiers
  logic supply_ok;
  logic tick;
  logic go_standby;
  // states that draw charge current
  function automatic logic is_charging(input ccs_state_e s);
    is_charging = (s == ST_PRECOND) || (s == ST_FAST) || (s == ST_CV);
  endfunction
  // first state of a new charge cycle
  function automatic ccs_state_e start_state(input logic low_bat);
    if (PRECOND_EN && low_bat) // RQ13
    begin
      start_state = ST_PRECOND; // RQ11
    end
    else
    begin
      start_state = ST_FAST;
    end
  endfunction
  // flag vector for the synchroniser
  assign raw = {TERM_CURRENT_I, BAT_AT_REGULATION_VOLTAGE_I, BAT_BELOW_PRECOND_I,
                BAT_ABOVE_REGULATION_HYS_I, BAT_BELOW_RECHARGE_THRESHOLD_I,
                CURRENT_SET_ENABLE_PIN_HIZ_I, CHARGE_ENABLE_HIGH_I,
                INPUT_OVERVOLTAGE_GUARD_I, POWER_DOWN_OK_I, VDD_MARGIN_OK_I,
                UNDERVOLTAGE_LOCKOUT_OK_I};
  // second stage taps
  assign s_undervoltage_lockout = cur.sync2[F_UNDERVOLTAGE_LOCKOUT];
  assign s_margin = cur.sync2[F_MARGIN];
  assign s_pd = cur.sync2[F_PD];
  assign s_ovp = cur.sync2[F_OVP];
  assign s_en = cur.sync2[F_EN];
  assign s_hiz = cur.sync2[F_HIZ];
  assign s_rechg = cur.sync2[F_RECHG];
  assign s_ovchg = cur.sync2[F_OVCHG];
  assign s_pre = cur.sync2[F_PRE];
  assign s_reg = cur.sync2[F_REG];
  assign s_term = cur.sync2[F_TERM];
  // operating window: lockout, margin, power-down, overvoltage
  assign supply_ok = s_undervoltage_lockout && s_margin && s_pd && !s_ovp; // RQ5
  // charge refused or suspended
  assign go_standby = s_hiz || !s_en || cur.inhibit || s_ovchg;
  // prescaler wrap gives one tick per ms
  assign tick = (cur.presc == TICK_CYCLES - 32'h0000_0001); // RQ21
  // all next-state logic
  always_comb
  begin
    next_cur = cur;
    // two-flop synchroniser
    next_cur.sync1 = raw; // RQ21
    next_cur.sync2 = cur.sync1;
    // free running prescaler
    if (tick)
    begin
      next_cur.presc = 32'h0000_0000;
    end
    else
    begin
      next_cur.presc = cur.presc + 32'h0000_0001;
    end
    // state flow, supply checks first
    if (!supply_ok)
    begin
      next_cur.st = ST_SHUTDOWN; // RQ1 RQ3 RQ4 RQ6
    end
    else
    begin
      case (cur.st)
        // power just valid, margin already seen
        ST_SHUTDOWN:
        begin
          next_cur.st = ST_STANDBY; // RQ2
          next_cur.safe_fault = 1'b0;
        end
        // wait for enable and battery
        ST_STANDBY:
        begin
          if (!go_standby && s_rechg) // RQ7 RQ8 RQ9 RQ10
          begin
            next_cur.st = start_state(s_pre);
          end
        end
        // low current until threshold
        ST_PRECOND:
        begin
          if (go_standby)
          begin
            next_cur.st = ST_STANDBY; // RQ8 RQ10
          end
          else if (!s_pre)
          begin
            next_cur.st = ST_FAST; // RQ12
          end
          else if (PRE_TIMER_EN && cur.ms_cnt >= PRE_TIMEOUT)
          begin
            next_cur.st = ST_FAULT; // RQ14
            next_cur.safe_fault = 1'b0;
          end
        end
        // full programmed current
        ST_FAST:
        begin
          if (go_standby)
          begin
            next_cur.st = ST_STANDBY;
          end
          else if (s_reg)
          begin
            next_cur.st = ST_CV; // RQ16
          end
          else if (SAFE_TIMER_EN && cur.ms_cnt >= SAFE_TIMEOUT)
          begin
            next_cur.st = ST_FAULT; // RQ20
            next_cur.safe_fault = 1'b1;
          end
        end
        // voltage held, wait for taper or timer
        ST_CV:
        begin
          if (go_standby)
          begin
            next_cur.st = ST_STANDBY;
          end
          else if (s_term || (SAFE_TIMER_EN && cur.ms_cnt >= SAFE_TIMEOUT))
          begin
            next_cur.st = ST_DONE;
          end
        end
        // complete, optional recharge
        ST_DONE:
        begin
          if (go_standby)
          begin
            next_cur.st = ST_STANDBY;
          end
          else if (AUTO_RECHARGE && s_rechg)
          begin
            next_cur.st = ST_FAST;
          end
        end
        // held until battery removed or power cycles
        ST_FAULT:
        begin
          if (s_ovchg)
          begin
            next_cur.st = ST_STANDBY; // RQ15
          end
        end
        default:
        begin
          next_cur.st = ST_SHUTDOWN;
        end
      endcase
    end
    // state timer, restarts on entry, runs on through cv
    if (next_cur.st != cur.st && next_cur.st != ST_CV)
    begin
      next_cur.ms_cnt = 32'h0000_0000; // RQ17
    end
    else if (tick && cur.ms_cnt != 32'hFFFF_FFFF)
    begin
      next_cur.ms_cnt = cur.ms_cnt + 32'h0000_0001;
    end
    // fault flash phase
    if (cur.st != ST_FAULT)
    begin
      next_cur.flash_cnt = 32'h0000_0000;
      next_cur.flash = 1'b1;
    end
    else if (tick)
    begin
      if (cur.flash_cnt == FLASH_TICKS - 32'h0000_0001)
      begin
        next_cur.flash_cnt = 32'h0000_0000;
        next_cur.flash = !cur.flash; // RQ19
      end
      else
      begin
        next_cur.flash_cnt = cur.flash_cnt + 32'h0000_0001;
      end
    end
    // status sink and current commands follow the new state
    next_cur.sink = is_charging(next_cur.st) ||
                    (FLASH_TYPE && next_cur.st == ST_FAULT && next_cur.flash); // RQ19
    next_cur.chg_on = is_charging(next_cur.st);
    next_cur.chg_low = (next_cur.st == ST_PRECOND); // RQ11
    // apb setup phase latches read data and error
    if (PSEL_I && !PENABLE_I)
    begin
      next_cur.slverr = 1'b0;
      next_cur.prdata = 32'h0000_0000;
      case (PADDR_I)
        OFF_CTRL:
        begin
          next_cur.prdata[CTRL_INH_BIT] = cur.inhibit;
        end
        OFF_STAT:
        begin
          next_cur.prdata[STAT_ST_LSB +: 3] = cur.st;
          next_cur.prdata[STAT_SINK_BIT] = cur.sink;
          next_cur.prdata[STAT_SAFE_BIT] = cur.safe_fault;
        end
        OFF_TIMER:
        begin
          next_cur.prdata = cur.ms_cnt;
        end
        OFF_FLAGS:
        begin
          next_cur.prdata[NFLAG-1:0] = cur.sync2;
        end
        default:
        begin
          next_cur.slverr = 1'b1;
        end
      endcase
    end
    // apb access phase write to control
    if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == OFF_CTRL && PSTRB_I[0])
    begin
      next_cur.inhibit = PWDATA_I[CTRL_INH_BIT];
    end
  end

  // single register stage, synchronous reset
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // bus answers, zero wait states
  assign PRDATA_O = cur.prdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = cur.slverr;
  // open drain: data low, enable low while sinking
  assign STAT_O = 1'b0; // RQ18
  assign STAT_OE_N_O = !cur.sink; // RQ18
  // current commands to the analog loop
  assign CHG_ON_O = cur.chg_on;
  assign CHG_LOW_CURRENT_O = cur.chg_low;

  // checks on the sequencer
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SRST_I);
  // start of a charge cycle from standby
  sequence s_start;
    cur.st == ST_STANDBY ##1 is_charging(cur.st);
  endsequence
  // precondition timer running out below threshold
  sequence s_pre_expire;
    cur.st == ST_PRECOND && s_pre && PRE_TIMER_EN && cur.ms_cnt >= PRE_TIMEOUT;
  endsequence
  // fault left toward standby
  sequence s_fault_exit;
    cur.st == ST_FAULT ##1 cur.st == ST_STANDBY;
  endsequence
  a_undervoltage_lockout_shutdown: assert property (!s_undervoltage_lockout |=> cur.st == ST_SHUTDOWN) // RQ1
    else $error("below lockout but not in shutdown");
  a_margin_leave: assert property ($fell(cur.st == ST_SHUTDOWN) |-> $past(s_margin)) // RQ2
    else $error("left shutdown without supply margin");
  a_margin_drop: assert property (cur.st != ST_SHUTDOWN && !s_margin |=> // RQ3
    cur.st == ST_SHUTDOWN)
    else $error("margin lost without shutdown");
  a_ovp_shutdown: assert property (s_ovp |=> cur.st == ST_SHUTDOWN [*1]) // RQ4
    else $error("overvoltage but not in shutdown");
  a_window_only: assert property (cur.st != ST_SHUTDOWN |-> // RQ5
    $past(s_undervoltage_lockout) && !$past(s_ovp))
    else $error("operating outside the supply window");
  a_pd_shutdown: assert property (!s_pd |=> cur.st == ST_SHUTDOWN) // RQ6
    else $error("power-down margin lost without shutdown");
  a_start_enable: assert property (s_start |-> $past(s_en, 1) && $past(s_pd, 1)) // RQ7
    else $error("charge started without enable");
  a_hiz_standby: assert property (s_hiz && cur.st != ST_FAULT |=> // RQ8
    !is_charging(cur.st))
    else $error("charging with program pin open");
  a_detect_start: assert property (s_start |-> $past(s_rechg, 1)) // RQ9
    else $error("charge started above recharge threshold");
  a_no_overchg: assert property (s_ovchg |=> !is_charging(cur.st)) // RQ10
    else $error("charging above regulation plus hysteresis");
  a_pre_entry: assert property (cur.st == ST_STANDBY ##1 cur.st == ST_PRECOND |-> // RQ11
    $past(s_pre, 1) && CHG_LOW_CURRENT_O && CHG_ON_O)
    else $error("precondition entry without low battery");
  a_pre_exit: assert property (cur.st == ST_PRECOND && supply_ok && !go_standby && !s_pre
    |=> cur.st == ST_FAST) // RQ12
    else $error("precondition not left above threshold");
  a_pre_option: assert property (!PRECOND_EN |-> cur.st != ST_PRECOND) // RQ13
    else $error("precondition entered while option is off");
  a_pre_fault: assert property (s_pre_expire ##0 supply_ok && !go_standby |=> // RQ14
    cur.st == ST_FAULT ##1 (cur.st == ST_FAULT || !$past(supply_ok) || $past(s_ovchg)))
    else $error("precondition timeout not held as fault");
  a_fault_exit: assert property (s_fault_exit |-> $past(s_ovchg, 1) && // RQ15
    STAT_OE_N_O)
    else $error("fault left without battery removal");
  a_cc_hold: assert property (cur.st == ST_FAST ##1 cur.st == ST_CV |-> // RQ16
    $past(s_reg, 1))
    else $error("constant current left before regulation");
  a_timer_clear: assert property ($rose(cur.st == ST_FAST) |-> cur.ms_cnt == 0) // RQ17
    else $error("safety timer not cleared on fast entry");
  a_stat_sink: assert property (is_charging(cur.st) |-> !STAT_OE_N_O && !STAT_O) // RQ19
    else $error("status not sinking while charging");
  a_stat_float: assert property ((cur.st == ST_STANDBY || cur.st == ST_DONE) // RQ19
    ##1 cur.st == $past(cur.st) |-> STAT_OE_N_O)
    else $error("status sinking while idle");
  a_safe_fault: assert property (cur.st == ST_FAST && supply_ok && !go_standby && // RQ20
    !s_reg && SAFE_TIMER_EN && cur.ms_cnt >= SAFE_TIMEOUT |=> cur.st == ST_FAULT)
    else $error("safety timeout in fast charge not faulted");
  a_sync_delay: assert property ($rose(raw[F_UNDERVOLTAGE_LOCKOUT]) ##1 1'b1 |=> // RQ21
    s_undervoltage_lockout || !$past(raw[F_UNDERVOLTAGE_LOCKOUT], 1))
    else $error("flag not through two sync stages");
endmodule

/* hw/ccs_pkg.sv */
// constants, state encoding and register image of the charge cycle sequencer
package ccs_pkg;
  // system clock rate and timer base
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 1000; // prescaler tick period in us
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  // precondition timer, minutes, and its length in ticks
  localparam int PRE_TIMER_MIN = 32;
  localparam int PRE_TICKS = PRE_TIMER_MIN * 60 * 1000;
  // elapsed safety timer, hours, and its length in ticks
  localparam int SAFE_TIMER_HR = 4;
  localparam int SAFE_TICKS = SAFE_TIMER_HR * 3600 * 1000;
  // status flash period in ms, half of it per phase
  localparam int FLASH_MS = 1600;
  localparam int FLASH_HALF = FLASH_MS / 2;
  // comparator flag positions in the synchroniser vector
  localparam int F_UNDERVOLTAGE_LOCKOUT = 0;
  localparam int F_MARGIN = 1;
  localparam int F_PD = 2;
  localparam int F_OVP = 3;
  localparam int F_EN = 4;
  localparam int F_HIZ = 5;
  localparam int F_RECHG = 6;
  localparam int F_OVCHG = 7;
  localparam int F_PRE = 8;
  localparam int F_REG = 9;
  localparam int F_TERM = 10;
  localparam int NFLAG = 11;
  // apb register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_TIMER = 12'h008;
  localparam logic [11:0] OFF_FLAGS = 12'h00C;
  // control register: bit 0 inhibits new charge and suspends a charge in progress
  localparam int CTRL_INH_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // status register fields
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_SINK_BIT = 4;
  localparam int STAT_SAFE_BIT = 5;
  // charge cycle states
  typedef enum logic [2:0] {
    ST_SHUTDOWN, ST_STANDBY, ST_PRECOND, ST_FAST, ST_CV, ST_DONE, ST_FAULT
  } ccs_state_e;
  // whole register image of the sequencer
  typedef struct packed {
    logic [NFLAG-1:0] sync1;
    logic [NFLAG-1:0] sync2;
    ccs_state_e st;
    logic [31:0] presc;
    logic [31:0] ms_cnt;
    logic [31:0] flash_cnt;
    logic flash;
    logic sink;
    logic chg_on;
    logic chg_low;
    logic inhibit;
    logic safe_fault;
    logic [31:0] prdata;
    logic slverr;
  } ccs_reg_s;
endpackage

/* tb/ccs_tb_stat_pullup.sv */
// far side model: pull-up resistor on the open-drain status pin
`timescale 1ns/1ps
module ccs_tb_stat_pullup (
  input wire logic stat_i,
  input wire logic stat_oe_n_i,
  output logic line_o
);
  // released pin floats up to the pull-up, an enabled sink pulls low
  assign line_o = stat_oe_n_i ? 1'b1 : stat_i;
endmodule

/* tb/tb_top.sv */
// self-checking bench for the charge cycle sequencer
`timescale 1ns/1ps
module tb_top;
  import ccs_pkg::*;
  localparam int SETTLE = 6; // flag sync plus two state hops
  localparam int TICK = 4; // shortened prescaler
  localparam int PRE_T = 8; // shortened precondition timeout, ticks
  localparam int SAFE_T = 40; // shortened safety timeout, ticks
  logic clk;
  logic srst;
  logic [10:0] fl; // comparator flags in package bit order
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr;
  logic stat, stat_oe_n, chg_on, chg_low, line;
  logic [32:0] exp_q[$]; // expected {error, read data} per read
  int fail_count;
  int num_checks;

  ccs_charge_cycle_sequencer #(.TICK_CYCLES(32'(TICK)), .PRE_TIMEOUT(32'(PRE_T)),
    .SAFE_TIMEOUT(32'(SAFE_T)), .FLASH_TICKS(32'h0000_0002)) i_ccs_charge_cycle_sequencer (
    .CORE_CLK_I(clk), .SRST_I(srst), .UNDERVOLTAGE_LOCKOUT_OK_I(fl[F_UNDERVOLTAGE_LOCKOUT]),
    .VDD_MARGIN_OK_I(fl[F_MARGIN]), .POWER_DOWN_OK_I(fl[F_PD]),
    .INPUT_OVERVOLTAGE_GUARD_I(fl[F_OVP]), .CHARGE_ENABLE_HIGH_I(fl[F_EN]),
    .CURRENT_SET_ENABLE_PIN_HIZ_I(fl[F_HIZ]), .BAT_BELOW_RECHARGE_THRESHOLD_I(fl[F_RECHG]),
    .BAT_ABOVE_REGULATION_HYS_I(fl[F_OVCHG]), .BAT_BELOW_PRECOND_I(fl[F_PRE]),
    .BAT_AT_REGULATION_VOLTAGE_I(fl[F_REG]), .TERM_CURRENT_I(fl[F_TERM]),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .STAT_O(stat), .STAT_OE_N_O(stat_oe_n), .CHG_ON_O(chg_on),
    .CHG_LOW_CURRENT_O(chg_low));

  ccs_tb_stat_pullup i_ccs_tb_stat_pullup (.stat_i(stat), .stat_oe_n_i(stat_oe_n),
    .line_o(line));

  // free running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // pseudo random source
  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // compare and count
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one apb transfer; a read notes its expected answer first
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    input logic [32:0] ex);
    if (!wr)
      exp_q.push_back(ex);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // apply a flag set and let it reach the state
  task automatic setf(input logic [10:0] v);
    @(posedge clk);
    fl <= v;
    repeat (SETTLE) @(posedge clk);
  endtask

  // state word over the bus, then the pins that follow the state
  task automatic expect_st(input ccs_state_e st, input logic safe);
    logic sink;
    sink = (st == ST_PRECOND || st == ST_FAST || st == ST_CV);
    apb(1'b0, OFF_STAT, 32'h0000_0000, {1'b0, 26'h0, safe, sink, 1'b0, 3'(st)});
    // pins read away from the edge that launches them
    @(negedge clk);
    check("chg_on", 33'(chg_on), 33'(sink));
    check("chg_low", 33'(chg_low), 33'(st == ST_PRECOND));
    check("stat_line", 33'(line), 33'(!sink));
  endtask

  // read monitor: oldest note against the answer at the access edge
  always @(posedge clk)
  begin
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("read_note", 33'h0, 33'h1);
      else
        check("prdata", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // hang guard
  initial
  begin
    repeat (4000) @(posedge clk);
    fail_count++;
    close_out();
  end

  // main sequence
  initial
  begin
    srst = 1'b1;
    fl = 11'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    lfsr = 32'h0000_beb5;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    // reset outputs read once settled
    @(negedge clk);
    check("oe_n_reset", 33'(stat_oe_n), 33'h1);
    apb(1'b0, OFF_CTRL, 32'h0000_0000, 33'(CTRL_RST));
    // shutdown held since release: timer shows one four-cycle tick
    apb(1'b0, OFF_TIMER, 32'h0000_0000, 33'h1);
    setf(11'h056);
    expect_st(ST_SHUTDOWN, 1'b0);
    setf(11'h157);
    expect_st(ST_PRECOND, 1'b0);
    setf(11'h057);
    expect_st(ST_FAST, 1'b0);
    setf(11'h257);
    expect_st(ST_CV, 1'b0);
    setf(11'h617);
    expect_st(ST_DONE, 1'b0);
    setf(11'h057);
    expect_st(ST_FAST, 1'b0);
    // lockout, margin, power-down and overvoltage each force shutdown
    for (int i = 0; i < 4; i++)
    begin
      setf(11'h057 ^ (11'h001 << i));
      expect_st(ST_SHUTDOWN, 1'b0);
      setf(11'h057);
      expect_st(ST_FAST, 1'b0);
    end
    // enable low, program pin open, battery over regulation
    for (int j = 4; j < 8; j++)
    begin
      if (j == 6)
        continue;
      setf(11'h057 ^ (11'h001 << j));
      expect_st(ST_STANDBY, 1'b0);
      setf(11'h057);
      expect_st(ST_FAST, 1'b0);
    end
    // software inhibit with random upper bits
    lfsr = next_lfsr(lfsr);
    apb(1'b1, OFF_CTRL, {lfsr[31:1], 1'b1}, 33'h0);
    repeat (SETTLE) @(posedge clk);
    expect_st(ST_STANDBY, 1'b0);
    apb(1'b0, OFF_CTRL, 32'h0000_0000, 33'h1);
    apb(1'b1, OFF_CTRL, 32'h0000_0000, 33'h0);
    apb(1'b1, OFF_STAT, 32'h0000_0007, 33'h0);
    repeat (SETTLE) @(posedge clk);
    expect_st(ST_FAST, 1'b0);
    // precondition timeout, fault held until battery removal
    setf(11'h177);
    setf(11'h157);
    repeat ((PRE_T - 3) * TICK) @(posedge clk);
    expect_st(ST_PRECOND, 1'b0);
    repeat (4 * TICK) @(posedge clk);
    expect_st(ST_FAULT, 1'b0);
    setf(11'h177);
    expect_st(ST_FAULT, 1'b0);
    setf(11'h1d7);
    expect_st(ST_STANDBY, 1'b0);
    setf(11'h157);
    expect_st(ST_PRECOND, 1'b0);
    // safety timer restarts on fast entry, then expires
    repeat ((PRE_T - 3) * TICK) @(posedge clk);
    setf(11'h057);
    repeat ((SAFE_T - 3) * TICK) @(posedge clk);
    expect_st(ST_FAST, 1'b0);
    repeat (4 * TICK) @(posedge clk);
    expect_st(ST_FAULT, 1'b1);
    setf(11'h056);
    // safety fault cause stays visible until shutdown is left
    expect_st(ST_SHUTDOWN, 1'b1);
    setf(11'h057);
    expect_st(ST_FAST, 1'b0);
    apb(1'b0, 12'h010, 32'h0000_0000, 33'h1_0000_0000);
    // random flag patterns through the synchroniser
    for (int k = 0; k < 4; k++)
    begin
      lfsr = next_lfsr(lfsr);
      @(posedge clk);
      fl <= lfsr[10:0];
      repeat (3) @(posedge clk);
      apb(1'b0, OFF_FLAGS, 32'h0000_0000, {22'h0, lfsr[10:0]});
    end
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule
